// [src/psc_regs.svh]
// constants for the pulse sensor position counter
`ifndef PSC_REGS_SVH
`define PSC_REGS_SVH

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define PSC_CLK_HZ 40000000
`define PSC_MIN_SEG_MS 10
// clock cycles in one 10 ms minimum segment, exactly 40000 per ms
`define PSC_MIN_SEG_CYCLES ((`PSC_CLK_HZ / 1000) * `PSC_MIN_SEG_MS)
`define PSC_FILTER_DEFAULT 20'h0_9C40
// ceiling on the programmed filter, a few cycles under one minimum segment
`define PSC_FILTER_MAX 20'h6_1A7C

// ------------------------------------------------------------
// widths and reset values
// ------------------------------------------------------------
`define PSC_COUNT_W 16
`define PSC_FILT_W 20
`define PSC_COUNT_RESET 16'h0000
`define PSC_FILT_ZERO 20'h0_0000
`define PSC_LEVEL_RESET 2'h0

`endif

// [src/psc_pkg.sv]
// types shared by the pulse sensor position counter
package psc_pkg;

   // ------------------------------------------------------------
   // axis carriers
   // ------------------------------------------------------------
   typedef struct packed {
      logic pulse;
      logic second_phase;
   } psc_sensor_type;

   typedef struct packed {
      logic move_cw;
      logic move_ccw;
   } psc_command_type;

   typedef enum logic {
      PSC_DIR_CW,
      PSC_DIR_CCW
   } psc_dir_type;

endpackage

// [src/psc_position_counter.sv]
// two-axis single-phase pulse sensor position counter
`timescale 1ns/1ps
`include "psc_regs.svh"

module psc_position_counter
   import psc_pkg::*;
#(
   parameter int unsigned COUNT_W = `PSC_COUNT_W,
   parameter int unsigned FILT_W = `PSC_FILT_W,
   parameter logic [`PSC_FILT_W-1:0] FILTER_CYCLES = `PSC_FILTER_DEFAULT
) (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire psc_sensor_type azimuth_sensor_i,
   input wire psc_sensor_type elevation_sensor_i,
   input wire psc_command_type azimuth_command_i,
   input wire psc_command_type elevation_command_i,
   input wire logic [FILT_W-1:0] filter_cycles_i,
   input wire logic [COUNT_W-1:0] preset_value_i,
   input wire logic [1:0] preset_i,
   output logic [COUNT_W-1:0] azimuth_position_o,
   output logic [COUNT_W-1:0] elevation_position_o,
   output logic [1:0] sensor_level_o,
   output logic [1:0] edge_seen_o
);

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   // zero on the port falls back to the default interval
   function automatic logic [FILT_W-1:0] filt_limit(input logic [FILT_W-1:0] prog);
      logic [FILT_W-1:0] lim;
      lim = (prog == FILT_W'(0)) ? FILT_W'(FILTER_CYCLES) : prog;
      // a longer filter would swallow a minimum-width segment
      if (lim > FILT_W'(`PSC_FILTER_MAX)) begin
         lim = FILT_W'(`PSC_FILTER_MAX);
      end
      filt_limit = lim;
   endfunction

   // one step per edge, wraps at the ends of the range
   function automatic logic [COUNT_W-1:0] step(input logic [COUNT_W-1:0] cnt, input psc_dir_type dir);
      step = (dir == PSC_DIR_CW) ? COUNT_W'(cnt + COUNT_W'(1)) : COUNT_W'(cnt - COUNT_W'(1));
   endfunction

   // both or neither move bit keeps the previous direction
   function automatic psc_dir_type next_dir(input psc_command_type cmd_in, input psc_dir_type last);
      next_dir = last;
      if (cmd_in.move_cw && !cmd_in.move_ccw) begin
         next_dir = PSC_DIR_CW;
      end else if (cmd_in.move_ccw && !cmd_in.move_cw) begin
         next_dir = PSC_DIR_CCW;
      end
   endfunction

   // ------------------------------------------------------------
   // axis fan-in
   // ------------------------------------------------------------
   psc_command_type cmd [2];
   logic [1:0] pulse_raw;

   assign cmd[0] = azimuth_command_i;
   assign cmd[1] = elevation_command_i;
   // second-phase bits deliberately unread
   assign pulse_raw = {elevation_sensor_i.pulse, azimuth_sensor_i.pulse};

   // ------------------------------------------------------------
   // synchroniser
   // ------------------------------------------------------------
   logic [1:0] sync1_q, sync1_d;
   logic [1:0] sync2_q, sync2_d;

   // the first stage may go metastable, so only the second feeds the filter
   always_comb begin
      sync1_d = pulse_raw;
      sync2_d = sync1_q;
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         sync1_q <= `PSC_LEVEL_RESET;
         sync2_q <= `PSC_LEVEL_RESET;
      end else begin
         sync1_q <= sync1_d;
         sync2_q <= sync2_d;
      end
   end

   // ------------------------------------------------------------
   // filter interval
   // ------------------------------------------------------------
   logic [FILT_W-1:0] limit;

   // shared by both axes
   always_comb begin
      limit = filt_limit(filter_cycles_i);
   end

   // ------------------------------------------------------------
   // glitch filter and accepted level
   // ------------------------------------------------------------
   logic [1:0] level_q, level_d;
   logic [FILT_W-1:0] filt_q [2];
   logic [FILT_W-1:0] filt_d [2];
   logic [1:0] accept;

   // a new level shows on level_q and the strobe limit + 2 clock edges
   // after it first reaches the pin
   always_comb begin
      level_d = level_q;
      accept = `PSC_LEVEL_RESET;
      for (int a = 0; a < 2; a++) begin
         filt_d[a] = filt_q[a];
         if (sync2_q[a] == level_q[a]) begin
            // a bounce back to the old level restarts the interval
            filt_d[a] = `PSC_FILT_ZERO;
         end else if (filt_q[a] + FILT_W'(1) >= limit) begin
            // stable long enough: accept the new level
            filt_d[a] = `PSC_FILT_ZERO;
            level_d[a] = sync2_q[a];
            accept[a] = 1'h1;
         end else begin
            filt_d[a] = FILT_W'(filt_q[a] + FILT_W'(1));
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         level_q <= `PSC_LEVEL_RESET;
         for (int a = 0; a < 2; a++) begin
            filt_q[a] <= `PSC_FILT_ZERO;
         end
      end else begin
         level_q <= level_d;
         for (int a = 0; a < 2; a++) begin
            filt_q[a] <= filt_d[a];
         end
      end
   end

   // ------------------------------------------------------------
   // last commanded direction
   // ------------------------------------------------------------
   psc_dir_type dir_q [2];
   psc_dir_type dir_d [2];

   // last command is held when driving stops
   always_comb begin
      for (int a = 0; a < 2; a++) begin
         dir_d[a] = next_dir(cmd[a], dir_q[a]);
      end
   end

   // reset starts clockwise
   always_ff @(posedge clk_i) begin
      for (int a = 0; a < 2; a++) begin
         if (reset_i) begin
            dir_q[a] <= PSC_DIR_CW;
         end else begin
            dir_q[a] <= dir_d[a];
         end
      end
   end

   // ------------------------------------------------------------
   // position counters
   // ------------------------------------------------------------
   logic [COUNT_W-1:0] count_q [2];
   logic [COUNT_W-1:0] count_d [2];

   // direction is the registered one, so a command in the
   // accepting cycle itself does not reach the step
   always_comb begin
      for (int a = 0; a < 2; a++) begin
         count_d[a] = count_q[a];
         if (accept[a]) begin
            count_d[a] = step(count_q[a], dir_q[a]);
         end
         // preset wins over an edge in the same cycle
         if (preset_i[a]) begin
            count_d[a] = preset_value_i;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      for (int a = 0; a < 2; a++) begin
         if (reset_i) begin
            count_q[a] <= `PSC_COUNT_RESET;
         end else begin
            count_q[a] <= count_d[a];
         end
      end
   end

   // ------------------------------------------------------------
   // edge strobe
   // ------------------------------------------------------------
   logic [1:0] edge_q, edge_d;

   // one-cycle strobe, registered together with the level it reports
   always_comb begin
      edge_d = accept;
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         edge_q <= `PSC_LEVEL_RESET;
      end else begin
         edge_q <= edge_d;
      end
   end

   // ------------------------------------------------------------
   // outputs, all straight from flops
   // ------------------------------------------------------------
   assign azimuth_position_o = count_q[0];
   assign elevation_position_o = count_q[1];
   assign sensor_level_o = level_q;
   assign edge_seen_o = edge_q;

endmodule

// [dv/psc_checker.sv]
// port assertions for the position counter
`timescale 1ns/1ps
module psc_checker
   import psc_pkg::*;
#(parameter int unsigned COUNT_W = 16, parameter int unsigned FILT_W = 20) (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire psc_sensor_type azimuth_sensor_i,
   input wire psc_command_type azimuth_command_i,
   input wire logic [1:0] preset_i,
   input wire logic [COUNT_W-1:0] azimuth_position_o,
   input wire logic [1:0] sensor_level_o,
   input wire logic [1:0] edge_seen_o
);
   logic last_ccw_q;
   always_ff @(posedge clk_i) begin
      if (reset_i) last_ccw_q <= 1'b0;
      else if (azimuth_command_i == 2'b01) last_ccw_q <= 1'b1;
      else if (azimuth_command_i == 2'b10) last_ccw_q <= 1'b0;
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (reset_i);
   // only valid while the filter is 6 cycles or less
   property p_lvl; $stable(azimuth_sensor_i.pulse)[*8] |-> sensor_level_o[0] == azimuth_sensor_i.pulse; endproperty
   a_lvl: assert property (p_lvl) else $error("level lost");
   property p_edge; edge_seen_o == (sensor_level_o ^ $past(sensor_level_o)); endproperty
   a_edge: assert property (p_edge) else $error("edge flag wrong");
   property p_hold; !edge_seen_o[0] && !$past(preset_i[0]) |-> $stable(azimuth_position_o); endproperty
   a_hold: assert property (p_hold) else $error("count moved");
   property p_cw; edge_seen_o[0] && !$past(preset_i[0]) && $past(azimuth_command_i, 2) == 2'b10
      && $past(azimuth_command_i, 3) == 2'b10 |-> azimuth_position_o == $past(azimuth_position_o) + 16'h0001; endproperty
   a_cw: assert property (p_cw) else $error("no increment");
   property p_ccw; edge_seen_o[0] && !$past(preset_i[0]) && $past(azimuth_command_i, 2) == 2'b01
      && $past(azimuth_command_i, 3) == 2'b01 |-> azimuth_position_o == $past(azimuth_position_o) + 16'hFFFF; endproperty
   a_ccw: assert property (p_ccw) else $error("no decrement");
   property p_dir; edge_seen_o[0] && !$past(preset_i[0]) |->
      azimuth_position_o == $past(azimuth_position_o) + ($past(last_ccw_q) ? 16'hFFFF : 16'h0001); endproperty
   a_dir: assert property (p_dir) else $error("step against last command");
endmodule
bind psc_position_counter psc_checker #(.COUNT_W(COUNT_W), .FILT_W(FILT_W)) i_chk (.clk_i(clk_i), .reset_i(reset_i),
   .azimuth_sensor_i(azimuth_sensor_i), .azimuth_command_i(azimuth_command_i), .preset_i(preset_i),
   .azimuth_position_o(azimuth_position_o), .sensor_level_o(sensor_level_o), .edge_seen_o(edge_seen_o));

// [dv/psc_sensor_model.sv]
// single-phase sensor, second phase never settles
`timescale 1ns/1ps
module psc_sensor_model #(parameter int SEG = 10) (
   input wire logic clk_i,
   input wire logic toggle_i,
   input wire logic glitch_i,
   output logic pulse_o,
   output logic second_phase_o
);
   int held = 0;
   initial pulse_o = 1'b0;
   initial second_phase_o = 1'b0;
   always @(negedge clk_i) begin
      held <= held + 1;
      second_phase_o <= ~second_phase_o;
      if (glitch_i) begin
         pulse_o <= ~pulse_o;
         held <= 0;
      end else if (toggle_i && held >= SEG) begin
         pulse_o <= ~pulse_o;
         held <= 0;
      end
   end
endmodule

// [dv/psc_position_counter_tb.sv]
// self-checking bench for the position counter
`timescale 1ns/1ps
module psc_position_counter_tb;
   import psc_pkg::*;
   logic clk_i = 0, reset_i = 1, da = 0, de = 0, ap, aq, ep, eq;
   logic [1:0] ac = 0, ec = 0, pre = 0, tg = 0, gl = 0, lv, es;
   logic [15:0] pv = 0, ap_o, ep_o, ea, ee, qa[$], qe[$];
   logic [31:0] r = 62;
   int error_cnt = 0, total_checks = 0;
   psc_sensor_model i_az (.clk_i(clk_i), .toggle_i(tg[0]), .glitch_i(gl[0]), .pulse_o(ap), .second_phase_o(aq));
   psc_sensor_model i_el (.clk_i(clk_i), .toggle_i(tg[1]), .glitch_i(gl[1]), .pulse_o(ep), .second_phase_o(eq));
   psc_position_counter i_dut (.clk_i(clk_i), .reset_i(reset_i), .azimuth_sensor_i({ap, aq}),
      .elevation_sensor_i({ep, eq}), .azimuth_command_i(ac), .elevation_command_i(ec), .filter_cycles_i(20'h0_0004),
      .preset_value_i(pv), .preset_i(pre), .azimuth_position_o(ap_o), .elevation_position_o(ep_o),
      .sensor_level_o(lv), .edge_seen_o(es));
   function automatic logic [31:0] xs(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      return x ^ (x << 5);
   endfunction
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: value mismatch", $time);
      end
   endtask
   task automatic close_out;
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   initial forever #12.5 clk_i = ~clk_i;
   initial begin
      repeat (20000) @(posedge clk_i);
      error_cnt++;
      close_out;
   end
   always @(negedge clk_i) begin
      if (es[0] === 1'b1 && qa.size() == 0) check(16'h0001, 16'h0000);
      else if (es[0] === 1'b1) check(ap_o, qa.pop_front());
      if (es[1] === 1'b1 && qe.size() == 0) check(16'h0001, 16'h0000);
      else if (es[1] === 1'b1) check(ep_o, qe.pop_front());
   end
   initial begin
      repeat (5) @(negedge clk_i);
      reset_i <= 0;
      r = xs(r);
      pv <= r[15:0];
      pre <= 2'b11;
      @(negedge clk_i);
      check(ap_o, pv);
      check(ep_o, pv);
      check({12'h000, lv, es}, 16'h0000);
      pre <= 0;
      ea = pv;
      ee = pv;
      for (int i = 0; i < 40; i++) begin
         r = xs(r);
         ac <= r[1:0];
         ec <= r[3:2];
         gl <= r[5:4];
         da = r[1:0] == 2'b01 ? 1'b1 : r[1:0] == 2'b10 ? 1'b0 : da;
         de = r[3:2] == 2'b01 ? 1'b1 : r[3:2] == 2'b10 ? 1'b0 : de;
         repeat (2) @(negedge clk_i);
         gl <= 0;
         if (r[6]) ac <= 0;
         repeat (11) @(negedge clk_i);
         tg <= r[8:7];
         ea = ea + (r[7] ? (da ? 16'hFFFF : 16'h0001) : 16'h0000);
         ee = ee + (r[8] ? (de ? 16'hFFFF : 16'h0001) : 16'h0000);
         if (r[7]) qa.push_back(ea);
         if (r[8]) qe.push_back(ee);
         @(negedge clk_i);
         tg <= 0;
         repeat (12) @(negedge clk_i);
      end
      check(16'(qa.size() + qe.size()), 16'h0000);
      close_out;
   end
endmodule
